// *** rtl/led_spi_port.sv ***
// Serial slave port giving a link master access to the paged register space
// Notes on behaviour
// - Four link signals: chip select, clock, master-out and master-in data.
// - Falling chip select starts a new transaction.
// - Master-out data is sampled on each rising serial clock edge.
// - Every byte on the link is eight clock cycles long.
// - Command byte: top bit direction, three identifier bits, four page bits.
// - Bytes arrive as command, then register address, then data.
// - Direction zero writes the data bytes; direction one reads.
// - Page field zero selects page zero, one selects page one.
// - Write pointer advances on the eighth rising edge of each data byte.
// - Pointer keeps advancing for every further byte of the transaction.
// - Serial clock stays within the maximum rate the port supports.
// - Reads shift register contents out on master-in after the address.
// - Read pointer advances on the eighth rising edge of each byte sent.
`default_nettype none

module led_spi_port
  import led_spi_pkg::*;
#(
  // Expected identifier field; arbitrary value
  parameter logic [2:0] CHIP_ID = 3'h5,
  parameter int PAGE_COUNT = 2
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sck_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  output logic spi_miso_oe_n_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic reg_page_out,
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in,
  output logic frame_active_out,
  output logic cmd_error_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Only two pages are decoded; page bit is a single flag
  if (PAGE_COUNT != 2) begin : g_page_count_check
    $error("led_spi_port: PAGE_COUNT must be 2");
  end

  // The bit counter must wrap exactly once per byte on the link
  if ((1 << BIT_CNT_W) != BYTE_W) begin : g_byte_width_check
    $error("led_spi_port: BIT_CNT_W does not match BYTE_W");
  end

  // The pin front end is built as a two-flop chain
  if (SYNC_STAGES != 2) begin : g_sync_check
    $error("led_spi_port: SYNC_STAGES must be 2");
  end

  // The identifier parameter must fill the command field exactly
  if ($bits(CHIP_ID) != CMD_ID_HI - CMD_ID_LO + 1) begin : g_id_width_check
    $error("led_spi_port: CHIP_ID width does not match the command field");
  end

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  // Clock edges are found by oversampling, so the usable serial clock
  // rate is bounded by the system clock: each clock phase must last at
  // least three system clocks for the read data to be loaded in time.
  // rate bound
  // The served link rate is thus a fraction of the system clock; a
  // master at the full link rate needs a faster system clock here.
  // All three pins share one chain so their relative order is kept.
  localparam logic [2:0] PIN_RESET = {CS_IDLE, SCK_IDLE, MOSI_IDLE};

  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic cs_n_level;
  logic mosi_level;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  pin_sync #(
    .WIDTH(3),
    .RESET_VAL(PIN_RESET)
  ) u_pin_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pin_in({spi_cs_n_in, spi_sck_in, spi_mosi_in}),
    .level_out(pin_level)
  );

  edge_finder #(
    .WIDTH(3),
    .RESET_VAL(PIN_RESET)
  ) u_edge_finder (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .level_in(pin_level),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  assign cs_n_level = pin_level[2];
  assign mosi_level = pin_level[0];
  assign sck_rise = pin_rise[1];
  assign sck_fall = pin_fall[1];
  assign cs_fall = pin_fall[2];
  assign cs_rise = pin_rise[2];

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  port_regs_t cur;
  port_regs_t next_cur;

  localparam port_regs_t REGS_RESET = '{
    state: ST_IDLE,
    bit_cnt: BIT_FIRST,
    rx_shift: BYTE_ZERO,
    dir: DIR_WRITE,
    selected: 1'b0,
    page_sel: 1'b0,
    addr: BYTE_ZERO,
    xfer_addr: BYTE_ZERO,
    wdata: BYTE_ZERO,
    wr_pulse: 1'b0,
    rd_pulse: 1'b0,
    load_pending: 1'b0,
    tx_shift: BYTE_ZERO,
    miso: MISO_IDLE,
    miso_oe_n: OE_N_OFF,
    cmd_error: 1'b0,
    frame_active: 1'b0
  };

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cur <= REGS_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Byte assembly and command decode
  // ----------------------------------------------------------------
  // The byte completing on this rise, with the new bit already shifted in
  logic [7:0] rx_byte;
  logic byte_done;
  logic [2:0] rx_id;
  logic [3:0] rx_page;
  logic id_ok;
  logic page_ok;

  assign rx_byte = {cur.rx_shift[6:0], mosi_level};
  assign byte_done = sck_rise && (cur.bit_cnt == BIT_LAST);
  assign rx_id = rx_byte[CMD_ID_HI:CMD_ID_LO];
  assign rx_page = rx_byte[CMD_PAGE_HI:CMD_PAGE_LO];
  assign id_ok = (rx_id == CHIP_ID);
  assign page_ok = (rx_page == PAGE_ZERO) || (rx_page == PAGE_ONE);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.wr_pulse = 1'b0;
    next_cur.rd_pulse = 1'b0;
    next_cur.cmd_error = 1'b0;
    next_cur.load_pending = cur.rd_pulse;

    // Read data is captured the cycle after the request is raised.
    // The fetch after the last byte of a read frame is never shifted
    // out, so the register file must allow reads without side effects.
    if (cur.load_pending) begin
      next_cur.tx_shift = cur.selected ? reg_rdata_in : BYTE_ZERO;
    end

    if (sck_rise && !cs_n_level) begin
      next_cur.rx_shift = rx_byte;
      next_cur.bit_cnt = cur.bit_cnt + 3'h1;
    end

    unique case (cur.state)
      ST_IDLE: begin
        next_cur.miso_oe_n = OE_N_OFF;
      end
      ST_CMD: begin
        if (byte_done) begin
          next_cur.dir = rx_byte[CMD_DIR_POS];
          next_cur.page_sel = (rx_byte[CMD_PAGE_HI:CMD_PAGE_LO] == PAGE_ONE);
          next_cur.selected = id_ok && page_ok;
          next_cur.cmd_error = !(id_ok && page_ok);
          // A rejected command still walks the byte order to the frame end
          // address follows command
          next_cur.state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (byte_done) begin
          next_cur.state = ST_DATA;
          next_cur.addr = rx_byte;
          // Fetching here leaves a whole clock phase for the data to arrive
          // before the first fall shifts it out
          // fetch first read byte
          if (cur.dir == DIR_READ) begin
            next_cur.xfer_addr = rx_byte;
            next_cur.addr = rx_byte + ADDR_STEP;
            next_cur.rd_pulse = cur.selected;
          end
        end
      end
      ST_DATA: begin
        if (byte_done) begin
          next_cur.xfer_addr = cur.addr;
          next_cur.addr = cur.addr + ADDR_STEP;
          if (cur.dir == DIR_WRITE) begin
            next_cur.wdata = rx_byte;
            next_cur.wr_pulse = cur.selected;
          end else begin
            next_cur.rd_pulse = cur.selected;
          end
        end
        // Enable turns on at the first fall, so the address byte sees it released
        // shift out on fall
        if (sck_fall && !cs_n_level && cur.dir == DIR_READ && cur.selected) begin
          next_cur.miso = cur.tx_shift[7];
          next_cur.tx_shift = {cur.tx_shift[6:0], 1'b0};
          next_cur.miso_oe_n = OE_N_ON;
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase

    // A select edge overrides whatever the byte logic above decided
    // new transaction
    if (cs_fall) begin
      next_cur.state = ST_CMD;
      next_cur.bit_cnt = BIT_FIRST;
      next_cur.rx_shift = BYTE_ZERO;
      next_cur.selected = 1'b0;
      next_cur.frame_active = 1'b1;
    end

    // Placed last so release wins over a shift or pulse in the same cycle
    // end and release
    if (cs_rise) begin
      next_cur.state = ST_IDLE;
      next_cur.bit_cnt = BIT_FIRST;
      next_cur.rx_shift = BYTE_ZERO;
      next_cur.selected = 1'b0;
      next_cur.miso = MISO_IDLE;
      next_cur.miso_oe_n = OE_N_OFF;
      next_cur.frame_active = 1'b0;
      next_cur.wr_pulse = 1'b0;
      next_cur.rd_pulse = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Link side
  assign spi_miso_out = cur.miso;
  assign spi_miso_oe_n_out = cur.miso_oe_n;

  // Pulses last one cycle; page, address and data hold at least until the
  // next byte completes, so the register file may take them a cycle late
  assign reg_wr_out = cur.wr_pulse;
  assign reg_rd_out = cur.rd_pulse;
  assign reg_page_out = cur.page_sel;
  assign reg_addr_out = cur.xfer_addr;
  assign reg_wdata_out = cur.wdata;

  // Status
  assign frame_active_out = cur.frame_active;
  assign cmd_error_out = cur.cmd_error;

endmodule // led_spi_port

`default_nettype wire

// *** rtl/led_spi_pkg.sv ***
// Shared constants and types for the LED matrix serial register port
`default_nettype none

package led_spi_pkg;

  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] ADDR_STEP = 8'h01;

  // ----------------------------------------------------------------
  // Command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_DIR_POS = 7;
  localparam int CMD_ID_HI = 6;
  localparam int CMD_ID_LO = 4;
  localparam int CMD_PAGE_HI = 3;
  localparam int CMD_PAGE_LO = 0;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] PAGE_ZERO = 4'h0;
  localparam logic [3:0] PAGE_ONE = 4'h1;

  // ----------------------------------------------------------------
  // Pin levels and timing
  // ----------------------------------------------------------------
  localparam logic CS_IDLE = 1'b1;
  localparam logic SCK_IDLE = 1'b0;
  localparam logic MOSI_IDLE = 1'b0;
  localparam logic MISO_IDLE = 1'b0;
  localparam logic OE_N_OFF = 1'b1;
  localparam logic OE_N_ON = 1'b0;
  localparam int MCLK_PERIOD_NS = 40;
  localparam int SCK_MAX_KHZ = 12000;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Port state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_ADDR = 4'b0100,
    ST_DATA = 4'b1000
  } port_state_t;

  typedef struct packed {
    port_state_t state;
    logic [2:0] bit_cnt;
    logic [7:0] rx_shift;
    logic dir;
    logic selected;
    logic page_sel;
    logic [7:0] addr;
    logic [7:0] xfer_addr;
    logic [7:0] wdata;
    logic wr_pulse;
    logic rd_pulse;
    logic load_pending;
    logic [7:0] tx_shift;
    logic miso;
    logic miso_oe_n;
    logic cmd_error;
    logic frame_active;
  } port_regs_t;

endpackage : led_spi_pkg

`default_nettype wire

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for asynchronous pin levels
`default_nettype none

module pin_sync
  import led_spi_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  // First stage feeds only the second stage; metastability settles there
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync: WIDTH must be at least one");
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      meta <= pin_in;
      level_out <= meta;
    end
  end

endmodule // pin_sync

`default_nettype wire

// *** rtl/edge_finder.sv ***
// Edge detector for synchronised levels, one pulse per transition
`default_nettype none

module edge_finder
  import led_spi_pkg::*;
#(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] rise_out,
  output logic [WIDTH-1:0] fall_out
);

  // ----------------------------------------------------------------
  // Previous level and per-bit edges
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] prev;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      prev <= RESET_VAL;
    end else begin
      prev <= level_in;
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_edge
    assign rise_out[i] = level_in[i] & ~prev[i];
    assign fall_out[i] = ~level_in[i] & prev[i];
  end

endmodule // edge_finder

`default_nettype wire

// *** verif/led_spi_checker.sv ***
// Concurrent checks on the serial register port outputs
`default_nettype none

module led_spi_checker
  import led_spi_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic spi_sck_in,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe_n_out,
  input wire logic reg_wr_out,
  input wire logic reg_rd_out,
  input wire logic reg_page_out,
  input wire logic [7:0] reg_addr_out,
  input wire logic frame_active_out,
  input wire logic cmd_error_out
);
  // ----------------------------------------------------------------
  // Last pulse address within the frame
  // ----------------------------------------------------------------
  logic have_prev;
  logic [7:0] prev_addr;
  logic pulse;
  assign pulse = reg_wr_out | reg_rd_out;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      have_prev <= 1'b0;
      prev_addr <= 8'h00;
    end else if (!frame_active_out) begin
      have_prev <= 1'b0;
    end else if (pulse) begin
      have_prev <= 1'b1;
      prev_addr <= reg_addr_out;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_wr_pulse; reg_wr_out |=> !reg_wr_out; endproperty
  property p_rd_pulse; reg_rd_out |=> !reg_rd_out; endproperty
  property p_excl; pulse |-> frame_active_out && !(reg_wr_out && reg_rd_out); endproperty
  property p_step; pulse && have_prev |-> reg_addr_out == prev_addr + ADDR_STEP; endproperty
  property p_page; pulse |-> $stable(reg_page_out); endproperty
  property p_release; $fell(frame_active_out) |-> ##[0:3] spi_miso_oe_n_out; endproperty
  property p_idle_low; spi_miso_oe_n_out |-> spi_miso_out == MISO_IDLE; endproperty
  property p_err; cmd_error_out |-> spi_miso_oe_n_out && !pulse ##1 !cmd_error_out; endproperty
  property p_miso_edge;
    $changed(spi_miso_out) && !spi_miso_oe_n_out && !$past(spi_miso_oe_n_out) |-> !spi_sck_in;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
  a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse too long");
  a_excl: assert property (p_excl) else $error("pulse outside frame");
  a_step: assert property (p_step) else $error("address did not step by one");
  a_page: assert property (p_page) else $error("page moved in frame");
  a_release: assert property (p_release) else $error("master-in not released");
  a_idle_low: assert property (p_idle_low) else $error("released line not low");
  a_err: assert property (p_err) else $error("bad command acted on");
  a_miso_edge: assert property (p_miso_edge) else $error("master-in moved while clock high");
  c_wr: cover property (reg_wr_out && have_prev);
  c_rd: cover property (reg_rd_out && have_prev);
  c_err: cover property (cmd_error_out);
endmodule // led_spi_checker

bind led_spi_port led_spi_checker i_chk (
  .mclk_in(mclk_in),
  .rst_in(rst_in),
  .spi_sck_in(spi_sck_in),
  .spi_miso_out(spi_miso_out),
  .spi_miso_oe_n_out(spi_miso_oe_n_out),
  .reg_wr_out(reg_wr_out),
  .reg_rd_out(reg_rd_out),
  .reg_page_out(reg_page_out),
  .reg_addr_out(reg_addr_out),
  .frame_active_out(frame_active_out),
  .cmd_error_out(cmd_error_out)
);

`default_nettype wire

// *** verif/spi_master_model.sv ***
// Link master model: mode 0, clock still outside frames
`default_nettype none

module spi_master_model #(
  parameter int HALF = 4
) (
  input wire logic mclk_in,
  input wire logic miso_in,
  input wire logic miso_oe_n_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic mosi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Link tasks
  // ----------------------------------------------------------------
  // master drives three lines
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    mosi_out = 1'b0;
  end
  task automatic half();
    repeat (HALF) @(negedge mclk_in);
  endtask
  task automatic start();
    cs_n_out = 1'b0;
    half();
  endtask
  // Released data line flips so a stale level never passes
  task automatic stop();
    half();
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    int i;
    rx = 8'h00;
    for (i = 0; i < nbits; i++) begin
      mosi_out = tx[7-i];
      half();
      sck_out = 1'b1;
      rx = {rx[6:0], miso_oe_n_in ? ~rx[0] : miso_in};
      half();
      sck_out = 1'b0;
    end
  endtask
endmodule // spi_master_model

`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the serial register port
`default_nettype none

module testbench
  import led_spi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Arbitrary identifier value
  localparam logic [2:0] ID = 3'h5;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic cs_n, sck, mosi, miso, oe_n, wr, rd, pg, act, err;
  logic [7:0] addr, wdata;
  logic [7:0] rdata = 8'h00;
  int n_mismatch = 0, check_count = 0, seed = 32'h367e, n_err = 0, n_oe = 0, n_rd = 0;
  logic [16:0] wr_q[$], exp_q[$];
  always #20 mclk_in = ~mclk_in;
  spi_master_model #(.HALF(4)) i_master (.mclk_in(mclk_in), .miso_in(miso), .miso_oe_n_in(oe_n),
    .cs_n_out(cs_n), .sck_out(sck), .mosi_out(mosi));
  led_spi_port #(.CHIP_ID(ID), .PAGE_COUNT(2)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
    .spi_cs_n_in(cs_n), .spi_sck_in(sck), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_n_out(oe_n), .reg_wr_out(wr), .reg_rd_out(rd), .reg_page_out(pg),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
    .frame_active_out(act), .cmd_error_out(err));
  // ----------------------------------------------------------------
  // Register file stand-in and monitors
  // ----------------------------------------------------------------
  function automatic logic [7:0] rd_fn(input logic p, input logic [7:0] a);
    return {a[3:0], a[7:4]} ^ {p, 7'h2b};
  endfunction
  always @(negedge mclk_in) rdata <= rd_fn(pg, addr);
  always @(posedge mclk_in) begin
    if (wr === 1'b1) wr_q.push_back({pg, addr, wdata});
    if (err === 1'b1) n_err++;
    if (rd === 1'b1) n_rd++;
    if (oe_n === 1'b0) n_oe++;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic frame(input logic dir, input logic [2:0] id, input logic [3:0] p,
                       input logic [7:0] a, input int n, input int cut);
    logic [7:0] rx, d, ea;
    logic ok;
    int i;
    ok = (id == ID) && (p == PAGE_ZERO || p == PAGE_ONE);
    i_master.start();
    i_master.xfer({dir, id, p}, 8, rx);
    i_master.xfer(a, 8, rx);
    for (i = 0; i < n; i++) begin
      d = 8'($random(seed));
      ea = a + 8'(i);
      i_master.xfer(d, (i == n - 1) ? cut : 8, rx);
      if (ok && (cut == 8 || i < n - 1)) begin
        if (dir == DIR_READ) check(rx, rd_fn(p[0], ea));
        else exp_q.push_back({p[0], ea, d});
      end
    end
    i_master.stop();
  endtask
  task automatic settle(input string name, input int errs, input int rds);
    int i;
    repeat (8) @(negedge mclk_in);
    check(wr_q.size(), exp_q.size());
    for (i = 0; i < exp_q.size() && i < wr_q.size(); i++) check(wr_q[i], exp_q[i]);
    check(n_err, errs);
    check(n_rd, rds);
    wr_q.delete();
    exp_q.delete();
    n_err = 0;
    n_oe = 0;
    n_rd = 0;
    $display("test %s done", name);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    #1ms;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    int k;
    repeat (10) @(posedge mclk_in);
    @(negedge mclk_in) rst_in = 1'b0;
    check({oe_n, wr, rd, pg, act, err, addr, wdata}, 22'h20_0000);
    for (k = 0; k < 6; k++) begin
      frame(DIR_WRITE, ID, 4'(k % 2), (k == 1) ? 8'hff : 8'($random(seed)), (k == 0) ? 1 : 1 + k % 4, 8);
      settle("write", 0, 0);
    end
    for (k = 0; k < 4; k++) begin
      frame(DIR_READ, ID, 4'(k % 2), (k == 0) ? 8'hfe : 8'($random(seed)), 1 + k, 8);
      settle("read", 0, k + 2);
    end
    frame(DIR_WRITE, 3'h2, PAGE_ZERO, 8'h10, 2, 8);
    frame(DIR_WRITE, ID, 4'h2, 8'h10, 2, 8);
    frame(DIR_READ, 3'h0, 4'hf, 8'h10, 2, 8);
    check(n_oe, 0);
    settle("error", 3, 0);
    frame(DIR_WRITE, ID, PAGE_ONE, 8'h20, 2, 4);
    settle("abort", 0, 0);
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
